// *** rtl/acc_ctl_pkg.sv ***
// Constants for the accumulator-adjust and processor-control unit
package acc_ctl_pkg;
  localparam logic [7:0] OP_IDLE    = 8'h00; // No-operation
  localparam logic [7:0] OP_DECADJ  = 8'h27; // Decimal adjust
  localparam logic [7:0] OP_INVERT  = 8'h2f; // One's complement
  localparam logic [7:0] OP_SETC    = 8'h37; // Set carry
  localparam logic [7:0] OP_CMPC    = 8'h3f; // Complement carry
  localparam logic [7:0] OP_HALT    = 8'h76; // Halt
  localparam logic [7:0] OP_MASK    = 8'hf3; // Mask interrupts
  localparam logic [7:0] OP_UNMASK  = 8'hfb; // Unmask interrupts
  localparam logic [7:0] OP_PREFIX  = 8'hed; // Extended prefix
  localparam logic [7:0] OP_NEGATE  = 8'h44; // Negate (after prefix)
  localparam logic [7:0] OP_MODE0   = 8'h46; // Select mode 0 (after prefix)
  localparam logic [7:0] OP_MODE1   = 8'h56; // Select mode 1 (after prefix)
  localparam logic [15:0] RESTART_ADDR = 16'h0038; // Mode 1 target
  localparam int unsigned T_PER_M   = 4;     // T states per machine cycle
  localparam logic [1:0]  T_LAST    = 2'h3;  // Last T state of a cycle
  localparam logic [7:0]  ACC_RESET = 8'hff; // Accumulator after reset
  localparam logic [7:0]  FLG_RESET = 8'hff; // Flags after reset
  localparam logic [15:0] PC_RESET  = 16'h0000; // Counter after reset
  // Flag bit positions
  localparam int unsigned F_C = 0;
  localparam int unsigned F_N = 1;
  localparam int unsigned F_P = 2;
  localparam int unsigned F_H = 4;
  localparam int unsigned F_Z = 6;
  localparam int unsigned F_S = 7;
endpackage

// *** rtl/acc_ctl_unit.sv ***
// Accumulator-adjust and processor-control execution unit
// Summary of operation
// - Add or subtract correction follows last arithmetic kind
// - Adjust adds 00/06/60/66 or 00/FA/A0/9A
// - Carry set when upper digit corrected
// - Half-carry follows correction table lower digit
// - Sign, zero, parity from result; subtract kept
// - Invert flips accumulator, sets half and subtract
// - Prefixed negate gives zero minus accumulator
// - Negate flags: subtract, carry, overflow, borrow
// - Complement carry; old carry into half-carry
// - Set carry; clear half-carry and subtract
// - Idle changes nothing, one machine cycle
// - Halt stops until interrupt or reset
// - Halted unit keeps running idle cycles
// - Mask clears both enable flip-flops
// - Masked requests ignored until unmask
// - Unmask sets both enable flip-flops
// - No acceptance during unmask or next instruction
// - Mode 0 takes first byte in acknowledge
// - Mode 1 restarts at fixed address
// - One or two four-T machine cycles
`timescale 1ns/100ps
`default_nettype none
module acc_ctl_unit (
  input  wire logic        clk,          // 100 MHz clock, one T state
  input  wire logic        rst,          // Synchronous reset
  input  wire logic [7:0]  data_in,      // Opcode byte bus
  input  wire logic        last_subtract,// Last arithmetic was subtract
  input  wire logic        irq_pin,      // Maskable request pin
  output logic             fetch,        // Opcode fetch cycle marker
  output logic             int_ack,      // Acknowledge cycle marker
  output logic             halted,       // Halt state
  output logic [7:0]       acc,          // Accumulator
  output logic [7:0]       flags,        // Flag register
  output logic [15:0]      pc,           // Program counter
  output logic             int_enable_ff_primary, // Enable flip-flop 1
  output logic             int_enable_ff_shadow,  // Enable flip-flop 2
  output logic             int_mode      // 0 or 1
);
  // Machine cycle kinds
  typedef enum logic [3:0] {
    ST_FETCH  = 4'b0001, // Opcode fetch
    ST_PREFIX = 4'b0010, // Second fetch after prefix
    ST_HALT   = 4'b0100, // Halted idle cycle
    ST_ACK    = 4'b1000  // Interrupt acknowledge
  } state_t;

  state_t      state, next_state;
  logic [1:0]  tcnt, next_tcnt;        // T state in machine cycle
  logic [7:0]  next_acc, next_flags;
  logic [15:0] next_pc;
  logic        next_int_enable_ff_primary, next_int_enable_ff_shadow, next_mode;
  logic        ei_hold, next_ei_hold;  // Unmask shadow pending
  logic        next_fetch, next_ack, next_halted;
  logic        irq_meta, irq_sync;     // Pin synchroniser
  logic        m_end;                  // Last T of machine cycle
  logic        take_irq;               // Accept at boundary
  // Decimal correction signals
  logic [3:0]  hi, lo;
  logic        cy, hc;
  logic [7:0]  corr, daa_res, neg_res;
  logic        daa_c, daa_h;

  // Synchronise request pin; first stage read only by second
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_pin;
      irq_sync <= irq_meta;
    end
  end

  assign m_end = (tcnt == acc_ctl_pkg::T_LAST);
  // Boundary sampling, gated by enable and unmask hold
  assign take_irq = irq_sync && int_enable_ff_primary && !ei_hold;
  assign hi = acc[7:4];
  assign lo = acc[3:0];
  assign cy = flags[acc_ctl_pkg::F_C];
  assign hc = flags[acc_ctl_pkg::F_H];
  assign neg_res = 8'h00 - acc;

  // Correction table; subtract side only reachable after subtract
  always_comb begin
    corr  = 8'h00;
    daa_c = 1'b0;
    daa_h = 1'b0;
    if (!last_subtract) begin
      if (cy || hi > 4'h9 || (hi == 4'h9 && lo > 4'h9)) begin
        corr  = 8'h60;
        daa_c = 1'b1;
      end
      if (hc || lo > 4'h9) begin
        corr  = corr | 8'h06;
        daa_h = (lo > 4'h9);
      end
    end else begin
      if (cy) begin
        corr  = 8'ha0;
        daa_c = 1'b1;
      end
      if (hc) begin
        corr  = cy ? 8'h9a : 8'hfa;
        daa_h = (lo < 4'h6);
      end
    end
  end
  assign daa_res = acc + corr; // wraps modulo 256

  // Next-state for sequencer, accumulator, flags and enables
  always_comb begin
    next_state  = state;
    next_tcnt   = tcnt + 2'h1;
    next_acc    = acc;     // nothing else written
    next_flags  = flags;
    next_pc     = pc;
    next_int_enable_ff_primary   = int_enable_ff_primary;
    next_int_enable_ff_shadow   = int_enable_ff_shadow;
    next_mode   = int_mode;
    next_ei_hold = ei_hold;
    next_ack    = 1'b0;
    next_halted = halted;
    if (m_end) begin
      next_tcnt = 2'h0;
      case (state)
        ST_FETCH, ST_HALT, ST_ACK: begin
          if (state == ST_FETCH) begin
            next_pc = pc + 16'h0001;
            next_ei_hold = 1'b0; // One instruction after unmask done
          end
          if (state == ST_ACK) begin
            if (int_mode) begin
              next_pc = acc_ctl_pkg::RESTART_ADDR;
            end else begin
              // Byte on bus is taken as the opcode below
              next_pc = pc;
            end
          end
          if (state == ST_HALT) begin
            next_state = ST_HALT; // idle cycles
          end else begin
            next_state = ST_FETCH;
          end
          // Halted cycles are idle: the bus byte is never decoded
          if (state != ST_HALT) begin
            if (state != ST_ACK || !int_mode) begin
              case (data_in)
                acc_ctl_pkg::OP_IDLE: begin
                  next_acc = acc;
                end
                acc_ctl_pkg::OP_DECADJ: begin
                  next_acc = daa_res;
                  next_flags[acc_ctl_pkg::F_C] = daa_c;
                  next_flags[acc_ctl_pkg::F_H] = daa_h;
                  next_flags[acc_ctl_pkg::F_S] = daa_res[7];
                  next_flags[acc_ctl_pkg::F_Z] = (daa_res == 8'h00);
                  next_flags[acc_ctl_pkg::F_P] = ~^daa_res;
                end
                acc_ctl_pkg::OP_INVERT: begin
                  next_acc = ~acc;
                  next_flags[acc_ctl_pkg::F_H] = 1'b1;
                  next_flags[acc_ctl_pkg::F_N] = 1'b1;
                end
                acc_ctl_pkg::OP_CMPC: begin
                  next_flags[acc_ctl_pkg::F_C] = ~cy;
                  next_flags[acc_ctl_pkg::F_H] = cy;
                  next_flags[acc_ctl_pkg::F_N] = 1'b0;
                end
                acc_ctl_pkg::OP_SETC: begin
                  next_flags[acc_ctl_pkg::F_C] = 1'b1;
                  next_flags[acc_ctl_pkg::F_H] = 1'b0;
                  next_flags[acc_ctl_pkg::F_N] = 1'b0;
                end
                acc_ctl_pkg::OP_HALT: begin
                  next_state  = ST_HALT;
                  next_halted = 1'b1;
                end
                acc_ctl_pkg::OP_MASK: begin
                  next_int_enable_ff_primary = 1'b0;
                  next_int_enable_ff_shadow = 1'b0;
                end
                acc_ctl_pkg::OP_UNMASK: begin
                  next_int_enable_ff_primary = 1'b1;
                  next_int_enable_ff_shadow = 1'b1;
                  next_ei_hold = 1'b1;
                end
                acc_ctl_pkg::OP_PREFIX: begin
                  next_state = ST_PREFIX;
                end
                default: begin
                  next_acc = acc; // Other groups not handled here
                end
              endcase
            end
          end
          // Accept at boundary; halt left by accepted interrupt
          if (next_state == ST_FETCH || next_state == ST_HALT) begin
            if (take_irq && next_ei_hold == 1'b0) begin
              next_state  = ST_ACK;
              next_ack    = 1'b1;
              next_halted = 1'b0;
              next_int_enable_ff_primary   = 1'b0;
              next_int_enable_ff_shadow   = 1'b0;
            end
          end
        end
        ST_PREFIX: begin
          next_pc    = pc + 16'h0001;
          next_state = ST_FETCH;
          case (data_in)
            acc_ctl_pkg::OP_NEGATE: begin
              next_acc = neg_res;
              next_flags[acc_ctl_pkg::F_S] = neg_res[7];
              next_flags[acc_ctl_pkg::F_Z] = (neg_res == 8'h00);
              next_flags[acc_ctl_pkg::F_H] = (lo != 4'h0);
              next_flags[acc_ctl_pkg::F_P] = (acc == 8'h80);
              next_flags[acc_ctl_pkg::F_N] = 1'b1;
              next_flags[acc_ctl_pkg::F_C] = (acc != 8'h00);
            end
            acc_ctl_pkg::OP_MODE0: next_mode = 1'b0;
            acc_ctl_pkg::OP_MODE1: next_mode = 1'b1;
            default: next_mode = int_mode;
          endcase
        end
        default: next_state = ST_FETCH;
      endcase
    end
    next_fetch = (next_tcnt == 2'h0) && (next_state == ST_FETCH
                 || next_state == ST_PREFIX);
    if (next_tcnt != 2'h0) begin
      next_ack = int_ack;
      next_fetch = fetch;
    end
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= ST_FETCH;
      tcnt    <= 2'h0;
      acc     <= acc_ctl_pkg::ACC_RESET;
      flags   <= acc_ctl_pkg::FLG_RESET;
      pc      <= acc_ctl_pkg::PC_RESET;
      int_enable_ff_primary <= 1'b0;
      int_enable_ff_shadow  <= 1'b0;
      int_mode <= 1'b0;
      ei_hold  <= 1'b0;
      fetch    <= 1'b1;
      int_ack  <= 1'b0;
      halted   <= 1'b0;
    end else begin
      state   <= next_state;
      tcnt    <= next_tcnt;
      acc     <= next_acc;
      flags   <= next_flags;
      pc      <= next_pc;
      int_enable_ff_primary <= next_int_enable_ff_primary;
      int_enable_ff_shadow  <= next_int_enable_ff_shadow;
      int_mode <= next_mode;
      ei_hold  <= next_ei_hold;
      fetch    <= next_fetch;
      int_ack  <= next_ack;
      halted   <= next_halted;
    end
  end

  // Checks
  property p_unmask_sets;
    @(posedge clk) disable iff (rst)
    (m_end && state == ST_FETCH && data_in == acc_ctl_pkg::OP_UNMASK
     && !take_irq) |=> int_enable_ff_primary && int_enable_ff_shadow;
  endproperty
  a_unmask_sets: assert property (p_unmask_sets)
    else $error("unmask did not set enables");
  property p_mask_clears;
    @(posedge clk) disable iff (rst)
    (m_end && state == ST_FETCH && data_in == acc_ctl_pkg::OP_MASK)
    |=> !int_enable_ff_primary && !int_enable_ff_shadow;
  endproperty
  a_mask_clears: assert property (p_mask_clears)
    else $error("mask did not clear enables");
  property p_no_ack_masked;
    @(posedge clk) disable iff (rst)
    (!int_enable_ff_primary && state != ST_ACK) |=> !int_ack;
  endproperty
  a_no_ack_masked: assert property (p_no_ack_masked)
    else $error("acknowledge while masked");
  property p_cycle_len;
    @(posedge clk) disable iff (rst) m_end |=> (tcnt == 2'h0) [*1] ##3 m_end;
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("machine cycle not four T states");
  property p_mode1_restart;
    @(posedge clk) disable iff (rst)
    (state == ST_ACK && m_end && int_mode) |=> pc == acc_ctl_pkg::RESTART_ADDR;
  endproperty
  a_mode1_restart: assert property (p_mode1_restart)
    else $error("mode 1 restart address wrong");
  property p_negate;
    @(posedge clk) disable iff (rst)
    (state == ST_PREFIX && m_end && data_in == acc_ctl_pkg::OP_NEGATE)
    |=> acc == 8'h00 - $past(acc) && flags[acc_ctl_pkg::F_N]
        && flags[acc_ctl_pkg::F_C] == ($past(acc) != 8'h00);
  endproperty
  a_negate: assert property (p_negate)
    else $error("negate result or flags wrong");
  property p_invert;
    @(posedge clk) disable iff (rst)
    (state == ST_FETCH && m_end && data_in == acc_ctl_pkg::OP_INVERT
     && !take_irq) |=> acc == ~$past(acc)
     && flags[acc_ctl_pkg::F_C] == $past(flags[acc_ctl_pkg::F_C]);
  endproperty
  a_invert: assert property (p_invert)
    else $error("invert wrong");
  property p_halt_stays;
    @(posedge clk) disable iff (rst)
    (halted && !take_irq) |=> halted || int_ack;
  endproperty
  a_halt_stays: assert property (p_halt_stays)
    else $error("halt left without interrupt");
  property p_halt_idle;
    @(posedge clk) disable iff (rst)
    (state == ST_HALT && m_end) |=> acc == $past(acc) && flags == $past(flags);
  endproperty
  a_halt_idle: assert property (p_halt_idle)
    else $error("halted cycle changed accumulator or flags");
  c_ack: cover property (@(posedge clk) int_ack);
  c_halt: cover property (@(posedge clk) halted ##[1:40] int_ack);
  c_neg: cover property (@(posedge clk) state == ST_PREFIX && m_end);
endmodule // acc_ctl_unit
`default_nettype wire

// *** verif/irq_source.sv ***
// Interrupting peripheral model: request line and acknowledge byte
`timescale 1ns/100ps
`default_nettype none
module irq_source (
  input  wire logic       clk,      // Processor clock
  input  wire logic       raise,    // Bench asks for an interrupt
  input  wire logic [7:0] ack_byte, // Instruction byte to hand over
  input  wire logic       int_ack,  // Acknowledge marker from the unit
  output logic            irq_pin,  // Request, active high
  output logic            drive,    // Peripheral owns the data bus
  output logic [7:0]      bus       // Byte placed on the bus
);
  logic served = 1'b0; // Request already answered

  // Drop the request once acknowledged so it is served only once
  always @(negedge clk) begin
    if (!raise)
      served <= 1'b0;
    else if (int_ack === 1'b1)
      served <= 1'b1;
  end

  assign irq_pin = raise & ~served;
  // Own the bus only in the acknowledge cycle
  assign drive   = int_ack;
  // Released bus shows a changed pattern, never the old byte
  assign bus     = int_ack ? ack_byte : ~ack_byte;
endmodule // irq_source
`default_nettype wire

// *** verif/bcd_adjust_and_cpu_control_tb.sv ***
// Self-checking bench for the accumulator-adjust and control unit
`timescale 1ns/100ps
`default_nettype none
module bcd_adjust_and_cpu_control_tb;
  logic        clk, rst;       // Clock and reset
  logic [7:0]  mem_op;         // Byte memory would return
  logic [7:0]  data_in;        // Bus seen by the unit
  logic        last_subtract;  // Kind of last arithmetic
  logic        raise;          // Ask for an interrupt
  logic [7:0]  ack_byte;       // Byte handed over on acknowledge
  logic        irq_pin, drive; // Peripheral outputs
  logic [7:0]  pbus;           // Peripheral bus value
  logic        fetch, int_ack, halted, ie1, ie2, int_mode;
  logic [7:0]  acc, flags;     // Unit state
  logic [15:0] pc;             // Program counter
  logic [7:0]  m_acc, m_f;     // Model accumulator and flags
  logic        m_ie, m_mode, m_halt;
  logic [7:0]  pool [10];      // Opcodes for the random stream
  int          miscompares, n_compared, ack_seen;

  // Peripheral wins the bus only while it drives
  assign data_in = drive ? pbus : mem_op;
  always #5 clk = ~clk;

  acc_ctl_unit dut (.clk(clk), .rst(rst), .data_in(data_in),
    .last_subtract(last_subtract), .irq_pin(irq_pin), .fetch(fetch),
    .int_ack(int_ack), .halted(halted), .acc(acc), .flags(flags),
    .pc(pc), .int_enable_ff_primary(ie1), .int_enable_ff_shadow(ie2),
    .int_mode(int_mode));
  irq_source peer (.clk(clk), .raise(raise), .ack_byte(ack_byte),
    .int_ack(int_ack), .irq_pin(irq_pin), .drive(drive), .bus(pbus));

  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Value compare; widths extend so unknowns still show
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Accumulator, flags, enables, mode and halt against the model; bits 5 and 3 are free
  task automatic chk_state();
    chk(acc, m_acc, "acc");
    chk(flags & 8'hd7, m_f & 8'hd7, "flags");
    chk(ie1, m_ie, "enable1");
    chk(ie2, m_ie, "enable2");
    chk(int_mode, m_mode, "mode");
    chk(halted, m_halt, "halted");
  endtask

  task automatic reset_model();
    m_acc = acc_ctl_pkg::ACC_RESET;
    m_f = acc_ctl_pkg::FLG_RESET;
    m_ie = 1'b0;
    m_mode = 1'b0;
    m_halt = 1'b0;
  endtask

  // One machine cycle; the accumulator may not change before its last edge
  task automatic exec(input logic [7:0] op);
    mem_op = op;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      if (int_ack === 1'b1)
        ack_seen++;
      if (i == 1)
        chk(fetch, !m_halt, "fetch");
      if (i == 2)
        chk(acc, m_acc, "early");
    end
  endtask

  // Reference behaviour of one instruction
  task automatic model(input logic [7:0] op);
    logic [7:0] a, c, n;
    logic h, cy;
    a = m_acc;
    c = 8'h00;
    h = m_f[4];
    cy = m_f[0];
    case (op)
      acc_ctl_pkg::OP_DECADJ: begin
        if (last_subtract) begin
          // Subtract side picks its correction from the flags alone
          c = {cy ? 4'h6 : 4'h0, h ? 4'h6 : 4'h0};
          h = h && a[3:0] < 4'h6;
          a = a - c;
        end else begin
          if (h || a[3:0] > 4'h9)
            c = 8'h06;
          if (cy || a > 8'h99) begin
            c = c | 8'h60;
            cy = 1'b1;
          end
          h = a[3:0] > 4'h9;
          a = a + c;
        end
        m_f = {a[7], a == 8'h00, 1'b0, h, 1'b0, ~^a, m_f[1], cy};
      end
      acc_ctl_pkg::OP_INVERT: begin
        a = ~a;
        m_f = m_f | 8'h12;
      end
      acc_ctl_pkg::OP_NEGATE: begin
        n = 8'h00 - a;
        m_f = {n[7], n == 8'h00, 1'b0, a[3:0] != 4'h0, 1'b0,
               a == 8'h80, 1'b1, a != 8'h00};
        a = n;
      end
      acc_ctl_pkg::OP_CMPC: m_f = {m_f[7:5], cy, m_f[3:2], 1'b0, ~cy};
      acc_ctl_pkg::OP_SETC: m_f = {m_f[7:5], 1'b0, m_f[3:2], 2'b01};
      acc_ctl_pkg::OP_MASK: m_ie = 1'b0;
      acc_ctl_pkg::OP_UNMASK: m_ie = 1'b1;
      acc_ctl_pkg::OP_MODE0: m_mode = 1'b0;
      acc_ctl_pkg::OP_MODE1: m_mode = 1'b1;
      acc_ctl_pkg::OP_HALT: m_halt = 1'b1;
      default: ;
    endcase
    m_acc = a;
  endtask

  // Prefixed opcodes take a prefix cycle first
  task automatic run(input logic [7:0] op);
    if (op inside {acc_ctl_pkg::OP_NEGATE, acc_ctl_pkg::OP_MODE0,
                   acc_ctl_pkg::OP_MODE1})
      exec(acc_ctl_pkg::OP_PREFIX);
    exec(op);
    model(op);
    chk_state();
  endtask

  // Bounded wait for acknowledge, then ride out its cycle
  task automatic wait_ack();
    int n;
    n = 0;
    while (int_ack !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      $display("BAD %0t no acknowledge", $time);
      summarize();
    end else begin
      repeat (4) @(negedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    mem_op = 8'h00;
    last_subtract = 1'b0;
    raise = 1'b0;
    ack_byte = 8'h00;
    pool = '{acc_ctl_pkg::OP_DECADJ, acc_ctl_pkg::OP_INVERT,
      acc_ctl_pkg::OP_NEGATE, acc_ctl_pkg::OP_CMPC, acc_ctl_pkg::OP_SETC,
      acc_ctl_pkg::OP_IDLE, acc_ctl_pkg::OP_MODE0, acc_ctl_pkg::OP_MODE1,
      acc_ctl_pkg::OP_MASK, acc_ctl_pkg::OP_UNMASK};
    reset_model();
    void'($urandom(15));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk_state();
    chk(pc, acc_ctl_pkg::PC_RESET, "pc");
    // Walk the accumulator to zero, then to 80h by subtract adjusts
    run(acc_ctl_pkg::OP_INVERT);
    run(acc_ctl_pkg::OP_NEGATE);
    last_subtract = 1'b1;
    repeat (4) begin
      run(acc_ctl_pkg::OP_SETC);
      run(acc_ctl_pkg::OP_DECADJ);
    end
    run(acc_ctl_pkg::OP_NEGATE);
    chk(acc, 8'h80, "neg 80h");
    // Random instruction stream with random add or subtract kind
    for (int k = 0; k < 400; k++) begin
      last_subtract = 1'($urandom());
      run(pool[$urandom_range(9)]);
    end
    // Mode 1: masked, then unmask delay, then restart
    run(acc_ctl_pkg::OP_MODE1);
    run(acc_ctl_pkg::OP_MASK);
    raise = 1'b1;
    ack_seen = 0;
    repeat (3) run(acc_ctl_pkg::OP_IDLE);
    run(acc_ctl_pkg::OP_UNMASK);
    run(acc_ctl_pkg::OP_IDLE);
    chk(16'(ack_seen), 16'h0000, "early ack");
    wait_ack();
    m_ie = 1'b0;
    chk_state();
    chk(pc, acc_ctl_pkg::RESTART_ADDR, "restart");
    raise = 1'b0;
    // Mode 0 out of halt: peripheral byte sets carry
    run(acc_ctl_pkg::OP_SETC);
    run(acc_ctl_pkg::OP_CMPC);
    run(acc_ctl_pkg::OP_MODE0);
    run(acc_ctl_pkg::OP_UNMASK);
    run(acc_ctl_pkg::OP_IDLE);
    run(acc_ctl_pkg::OP_HALT);
    repeat (3) begin
      exec(acc_ctl_pkg::OP_INVERT);
      chk_state();
    end
    ack_byte = acc_ctl_pkg::OP_SETC;
    raise = 1'b1;
    wait_ack();
    m_ie = 1'b0;
    m_halt = 1'b0;
    model(acc_ctl_pkg::OP_SETC);
    chk_state();
    raise = 1'b0;
    // Reset in mid-run also ends a halt
    run(acc_ctl_pkg::OP_HALT);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reset_model();
    chk_state();
    run(acc_ctl_pkg::OP_IDLE);
    summarize();
  end
endmodule // bcd_adjust_and_cpu_control_tb
`default_nettype wire
